// file: core/psc_loader.v
// device end of the passive serial configuration interface
// pins arrive asynchronously; open-drain lines resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

module psc_loader #(
    parameter                 CFG_BITS     = 64,
    parameter                 AUTO_RESTART = 1,
    parameter [`PSC_CNT_W-1:0] POR_CYCLES  = `PSC_POR_CYCLES
) (
    // clock and reset
    input  wire               clk,
    input  wire               reset,
    // host-driven pins
    input  wire               config_req_n,
    input  wire               serial_config_clock,
    input  wire               serial_data,
    input  wire               user_startup_clock,
    // start-up option strap
    input  wire               use_user_clock,
    // open-drain status line
    input  wire               status_n_in,
    output wire               status_n_out,
    output wire               status_n_oe,
    // open-drain configuration-complete line
    input  wire               conf_done_in,
    output wire               conf_done_out,
    output wire               conf_done_oe,
    // user side
    output wire               user_mode,
    output wire               user_data,
    output wire               cfg_error
);

    localparam [6:0] S_POR   = 7'h01;
    localparam [6:0] S_RST   = 7'h02;
    localparam [6:0] S_CFG   = 7'h04;
    localparam [6:0] S_CD2CU = 7'h08;
    localparam [6:0] S_INIT  = 7'h10;
    localparam [6:0] S_USER  = 7'h20;
    localparam [6:0] S_ERR   = 7'h40;

    localparam [`PSC_CNT_W-1:0] STATUS_CYC = `PSC_STATUS_CYCLES;
    localparam [`PSC_CNT_W-1:0] CD2UM_CYC  = `PSC_CD2UM_CYCLES;
    localparam [`PSC_CNT_W-1:0] CD2CU_CYC  = `PSC_CD2CU_CYCLES;
    localparam [`PSC_CNT_W-1:0] USR_CYC    = `PSC_USR_CYCLES;
    localparam [`PSC_CNT_W-1:0] BITS_CYC   = CFG_BITS;

    // accepted level changes only when stages two and three agree
    function filt;
        input s2;
        input s3;
        input lvl;
        begin
            filt = (s2 == s3) ? s3 : lvl;
        end
    endfunction

    reg  [2:0]            req_s_ff;
    reg  [2:0]            sck_s_ff;
    reg  [2:0]            dat_s_ff;
    reg  [2:0]            usr_s_ff;
    reg  [2:0]            opt_s_ff;
    reg  [2:0]            sts_s_ff;
    reg                   req_ff;
    reg                   sck_ff;
    reg                   dat_ff;
    reg                   usr_ff;
    reg                   opt_ff;
    reg                   sts_ff;
    reg  [6:0]            state_ff;
    reg  [6:0]            nxt_state;
    reg  [`PSC_CNT_W-1:0] cnt_ff;
    reg  [`PSC_CNT_W-1:0] nxt_cnt;
    reg                   par_ff;
    reg                   nxt_par;
    reg                   status_oe_ff;
    reg                   done_oe_ff;
    reg                   user_mode_ff;
    reg                   user_data_ff;
    reg                   err_ff;
    reg                   nxt_err;

    wire req_lvl = filt(req_s_ff[1], req_s_ff[2], req_ff);
    wire sck_lvl = filt(sck_s_ff[1], sck_s_ff[2], sck_ff);
    wire dat_lvl = filt(dat_s_ff[1], dat_s_ff[2], dat_ff);
    wire usr_lvl = filt(usr_s_ff[1], usr_s_ff[2], usr_ff);
    wire opt_lvl = filt(opt_s_ff[1], opt_s_ff[2], opt_ff);
    wire sts_lvl = filt(sts_s_ff[1], sts_s_ff[2], sts_ff);
    wire req_fall = req_ff & ~req_lvl;
    wire sck_rise = ~sck_ff & sck_lvl;
    wire usr_rise = ~usr_ff & usr_lvl;

    always @(posedge clk) begin
        if (reset) begin
            req_s_ff <= 3'h7;
            sck_s_ff <= 3'h0;
            dat_s_ff <= 3'h0;
            usr_s_ff <= 3'h0;
            opt_s_ff <= 3'h0;
            sts_s_ff <= 3'h0;
            sts_ff   <= 1'b0;
            req_ff   <= 1'b1;
            sck_ff   <= 1'b0;
            dat_ff   <= 1'b0;
            usr_ff   <= 1'b0;
            opt_ff   <= 1'b0;
        end else begin
            req_s_ff <= {req_s_ff[1:0], config_req_n};
            sck_s_ff <= {sck_s_ff[1:0], serial_config_clock};
            dat_s_ff <= {dat_s_ff[1:0], serial_data};
            usr_s_ff <= {usr_s_ff[1:0], user_startup_clock};
            opt_s_ff <= {opt_s_ff[1:0], use_user_clock};
            sts_s_ff <= {sts_s_ff[1:0], status_n_in};
            sts_ff   <= sts_lvl;
            req_ff   <= req_lvl;
            sck_ff   <= sck_lvl;
            dat_ff   <= dat_lvl;
            usr_ff   <= usr_lvl;
            opt_ff   <= opt_lvl;
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_par   = par_ff;
        nxt_err   = err_ff;
        case (state_ff)
            S_POR: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= POR_CYCLES - 1'b1) begin
                    nxt_state = S_RST;
                    nxt_cnt   = {`PSC_CNT_W{1'b0}};
                end
            end
            // status low for the minimum hold
            S_RST: begin
                if (cnt_ff < STATUS_CYC) begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
                if (cnt_ff >= STATUS_CYC && req_lvl) begin
                    nxt_state = S_CFG;
                    nxt_cnt   = {`PSC_CNT_W{1'b0}};
                    nxt_par   = 1'b0;
                end
            end
            S_CFG: begin
                if (sck_rise) begin
                    nxt_cnt = cnt_ff + 1'b1;
                    nxt_par = par_ff ^ dat_lvl;
                    if (cnt_ff == BITS_CYC - 1'b1) begin
                        nxt_cnt = {`PSC_CNT_W{1'b0}};
                        if (par_ff ^ dat_lvl) begin
                            nxt_state = S_ERR;
                            nxt_err   = 1'b1;
                        end else begin
                            nxt_state = S_CD2CU;
                            nxt_err   = 1'b0;
                        end
                    end
                end
                // external error pulls status low; the synced line still
                // shows our own pull-down for a few cycles after release, so trust it
                // only once bits flow (host waits after status high)
                if (!sts_lvl && (sck_rise || cnt_ff != {`PSC_CNT_W{1'b0}})) begin
                    nxt_state = S_ERR;
                    nxt_cnt   = {`PSC_CNT_W{1'b0}};
                end
            end
            S_CD2CU: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= CD2CU_CYC - 1'b1) begin
                    nxt_state = S_INIT;
                    nxt_cnt   = {`PSC_CNT_W{1'b0}};
                end
            end
            S_INIT: begin
                if (opt_lvl) begin
                    if (usr_rise) begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                    if (usr_rise && cnt_ff == USR_CYC - 1'b1) begin
                        nxt_state = S_USER;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff >= CD2UM_CYC - CD2CU_CYC - 1'b1) begin
                        nxt_state = S_USER;
                    end
                end
            end
            S_USER: begin
                nxt_cnt = {`PSC_CNT_W{1'b0}};
            end
            S_ERR: begin
                if (cnt_ff < STATUS_CYC) begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
                if (cnt_ff >= STATUS_CYC && AUTO_RESTART != 0 && req_lvl) begin
                    nxt_state = S_CFG;
                    nxt_cnt   = {`PSC_CNT_W{1'b0}};
                    nxt_par   = 1'b0;
                end
            end
            default: begin
                nxt_state = S_POR;
                nxt_cnt   = {`PSC_CNT_W{1'b0}};
            end
        endcase
        // request low restarts from any state but power-on
        if (state_ff != S_POR && (req_fall || !req_lvl)) begin
            if (state_ff != S_RST || req_fall) begin
                nxt_cnt = {`PSC_CNT_W{1'b0}};
            end
            nxt_state = S_RST;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state_ff     <= S_POR;
            cnt_ff       <= {`PSC_CNT_W{1'b0}};
            par_ff       <= 1'b0;
            err_ff       <= 1'b0;
            status_oe_ff <= 1'b1;
            done_oe_ff   <= 1'b1;
            user_mode_ff <= 1'b0;
            user_data_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            par_ff       <= nxt_par;
            err_ff       <= nxt_err;
            status_oe_ff <= (nxt_state == S_POR) || (nxt_state == S_RST) || (nxt_state == S_ERR);
            done_oe_ff   <= (nxt_state == S_POR) || (nxt_state == S_RST) ||
                            (nxt_state == S_CFG) || (nxt_state == S_ERR);
            user_mode_ff <= (nxt_state == S_USER);
            user_data_ff <= (nxt_state == S_USER) ? dat_lvl : 1'b0;
        end
    end

    // open-drain lines only ever pull low
    reg status_o_ff;
    reg done_o_ff;
    always @(posedge clk) begin
        status_o_ff <= 1'b0;
        done_o_ff   <= 1'b0;
    end

    assign status_n_out  = status_o_ff;
    assign status_n_oe   = status_oe_ff;
    assign conf_done_out = done_o_ff;
    assign conf_done_oe  = done_oe_ff;
    assign user_mode     = user_mode_ff;
    assign user_data     = user_data_ff;
    assign cfg_error     = err_ff;

endmodule
`default_nettype wire

// file: core/psc_regs.vh
// constants for the passive serial configuration loader
// assumes a 25 MHz core clock; times kept in printed units
// Notes on behaviour
// - user mode: lines high; request low reconfigures
// - status held low through power-on delay
// - complete line low until data accepted
// - request low pulls complete, status low quickly
// - status low between ten and hundred us
// - status released within 100 us after request
// - data sampled on serial clock rising edge
// - internal oscillator start-up takes 20-40 us
// - user clock accepted four clock periods later
// - 299 user clock cycles then user mode
// - data pin becomes user pin afterwards
// - error pulls status low, resets internally
// - good data releases complete line, start-up
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

`define PSC_CLK_KHZ        25000
`define PSC_CLK_NS         40
`define PSC_POR_MIN_MS     12
`define PSC_POR_CYCLES     (`PSC_POR_MIN_MS * `PSC_CLK_KHZ)
`define PSC_STATUS_MIN_US  10
`define PSC_STATUS_CYCLES  ((`PSC_STATUS_MIN_US * `PSC_CLK_KHZ + 999) / 1000)
`define PSC_CD2UM_MIN_US   20
`define PSC_CD2UM_CYCLES   ((`PSC_CD2UM_MIN_US * `PSC_CLK_KHZ + 999) / 1000)
`define PSC_SERIAL_CONFIG_CLOCK_MAX_NS    10
`define PSC_CD2CU_PERIODS  4
`define PSC_CD2CU_CYCLES   ((`PSC_CD2CU_PERIODS * `PSC_SERIAL_CONFIG_CLOCK_MAX_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_USR_CYCLES     299
`define PSC_CNT_W          20

`endif

// file: tb/psc_loader_properties.sv
// checker: timing relations on the loader's pins
// assumes one clock domain, reset synchronous active high
`timescale 1ns/1ps
`default_nettype none
module psc_loader_properties #(
    parameter int POR_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins
    input wire logic config_req_n,
    input wire logic user_startup_clock,
    input wire logic use_user_clock,
    input wire logic status_n_out,
    input wire logic status_n_oe,
    input wire logic conf_done_out,
    input wire logic conf_done_oe,
    input wire logic user_mode,
    input wire logic user_data,
    input wire logic cfg_error
);
    logic [19:0] st_cnt_ff;
    logic [19:0] rh_cnt_ff;
    logic [15:0] cd_cnt_ff;
    logic [8:0]  uc_cnt_ff;
    logic [3:0]  uc_sync_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // user clock edges seen with the pin path's latency; counting starts
    // one cycle after complete releases, once that clock is accepted
    always @(posedge clk) begin
        if (reset) begin
            st_cnt_ff <= 20'h00000;
            rh_cnt_ff <= 20'h00000;
            cd_cnt_ff <= 16'h0000;
            uc_cnt_ff <= 9'h000;
            uc_sync_ff <= 4'h0;
        end else begin
            st_cnt_ff <= status_n_oe ? st_cnt_ff + 20'h00001 : 20'h00000;
            rh_cnt_ff <= (status_n_oe && config_req_n) ? rh_cnt_ff + 20'h00001 : 20'h00000;
            cd_cnt_ff <= conf_done_oe ? 16'h0000 : cd_cnt_ff + 16'h0001;
            uc_sync_ff <= {uc_sync_ff[2:0], user_startup_clock};
            uc_cnt_ff <= conf_done_oe ? 9'h000
                : uc_cnt_ff + {8'h00, uc_sync_ff[3:2] == 2'h1 && cd_cnt_ff != 16'h0000};
        end
    end
    a_req_pulls_low: assert property ($fell(config_req_n) |-> ##[1:20] (status_n_oe && conf_done_oe))
        else $error("request fall not answered");
    a_por_holds: assert property ($fell(reset) |-> (status_n_oe && conf_done_oe)[*8])
        else $error("lines released during power-on");
    a_status_min: assert property ($fell(status_n_oe) |-> st_cnt_ff >= 20'h000fa)
        else $error("status low too short");
    a_status_release: assert property (rh_cnt_ff < POR_CYCLES + 20'h009ce)
        else $error("status not released in time");
    a_done_release: assert property ($fell(conf_done_oe) |-> !status_n_oe && config_req_n && !cfg_error)
        else $error("complete released outside configuration");
    a_internal_start: assert property ($rose(user_mode) && !use_user_clock
        |-> cd_cnt_ff >= 16'h01f2 && cd_cnt_ff <= 16'h03e8)
        else $error("internal start-up time wrong");
    a_user_clock: assert property ($rose(user_mode) && use_user_clock
        |-> uc_cnt_ff >= 9'h12b && uc_cnt_ff <= 9'h12d)
        else $error("user clock count wrong");
    a_req_leaves_user: assert property ($fell(config_req_n) |-> ##[1:20] !user_mode)
        else $error("user mode kept after request");
    a_error_pulls: assert property ($rose(cfg_error) |-> (status_n_oe && conf_done_oe)[*8])
        else $error("error without status low");
    a_user_pin: assert property (!user_mode && !$past(user_mode) |-> !user_data)
        else $error("user data outside user mode");
    a_open_drain: assert property (!status_n_out && !conf_done_out)
        else $error("open-drain output high");
endmodule
bind psc_loader psc_loader_properties #(.POR_CYCLES(POR_CYCLES)) props (
    .clk(clk), .reset(reset), .config_req_n(config_req_n), .user_startup_clock(user_startup_clock),
    .use_user_clock(use_user_clock), .status_n_out(status_n_out), .status_n_oe(status_n_oe),
    .conf_done_out(conf_done_out), .conf_done_oe(conf_done_oe), .user_mode(user_mode),
    .user_data(user_data), .cfg_error(cfg_error));
`default_nettype wire

// file: tb/psc_host_model.sv
// host model: request pulse, waits, then one serial stream
// assumes the status line is resolved with a pull-up outside
`timescale 1ns/1ps
`default_nettype none
module psc_host_model #(
    parameter int BITS = 64
) (
    // control from bench
    input  wire logic start,
    input  wire logic bad,
    // device lines
    input  wire logic status_n,
    output var  logic config_req_n,
    output var  logic sclk,
    output var  logic sdata,
    output var  logic busy
);
    initial begin
        config_req_n = 1'b1;
        sclk = 1'b0;
        sdata = 1'b0;
        busy = 1'b0;
    end
    always @(posedge start) begin
        busy = 1'b1;
        config_req_n = 1'b0;
        #2040;
        config_req_n = 1'b1;
        #100040;
        wait (status_n === 1'b1);
        #2040;
        // data moves on falling edge; even parity unless bad
        for (int i = 0; i < BITS; i++) begin
            sdata = (i % 3 == 0) ^ (bad && i == BITS - 1);
            #160 sclk = 1'b1;
            #160 sclk = 1'b0;
        end
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// file: tb/tb_passive_serial_config_timing.sv
// bench: power-on, good stream, bad stream, user-clock start-up
// assumes pull-ups on both open-drain lines, modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_passive_serial_config_timing;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic bad = 1'b0;
    logic use_uc = 1'b0;
    logic uclk = 1'b0;
    logic arm = 1'b0;
    int   n_tests = 0;
    int   n_mismatch = 0;
    int   uc_n = 0;
    int   n;
    wire logic req_n, sclk, sdata, busy, st_out, st_oe, cd_out, cd_oe, umode, udata, err;
    wire logic st_n = !(st_oe && !st_out);
    wire logic cd = !(cd_oe && !cd_out);
    always #20 clk = ~clk;
    always #160 uclk = ~uclk;
    always @(posedge uclk) if (arm) uc_n++;
    psc_host_model host (.start(start), .bad(bad), .status_n(st_n), .config_req_n(req_n),
        .sclk(sclk), .sdata(sdata), .busy(busy));
    psc_loader #(.POR_CYCLES(20'h00014)) dut (.clk(clk), .reset(reset), .config_req_n(req_n),
        .serial_config_clock(sclk), .serial_data(sdata), .user_startup_clock(uclk),
        .use_user_clock(use_uc), .status_n_in(st_n), .status_n_out(st_out), .status_n_oe(st_oe),
        .conf_done_in(cd), .conf_done_out(cd_out), .conf_done_oe(cd_oe), .user_mode(umode),
        .user_data(udata), .cfg_error(err));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task kick(input logic b);
        @(posedge clk) #1;
        bad = b;
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
    endtask
    task finish_host;
        for (int k = 0; k < 4000 && busy === 1'b1; k++) @(posedge clk);
        for (int k = 0; k < 40 && cd_oe !== 1'b0; k++) @(posedge clk);
        #1;
    endtask
    task t_por;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk) #1;
            chk(st_oe, 1'b1);
        end
        chk({cd_oe, umode}, 2'h2);
    endtask
    task t_good;
        kick(1'b0);
        finish_host;
        chk(cd, 1'b1);
        n = 0;
        for (int k = 0; k < 1100 && umode !== 1'b1; k++) begin
            @(posedge clk) #1;
            n++;
        end
        chk(n >= 495 && n <= 1000, 1'b1);
        chk({st_n, req_n, cd}, 3'h7);
        repeat (8) @(posedge clk) #1;
        chk(udata, sdata);
    endtask
    task t_err;
        kick(1'b1);
        repeat (19) @(posedge clk) #1;
        chk({st_oe, cd_oe, umode}, 3'h6);
        finish_host;
        chk({err, cd_oe}, 2'h3);
    endtask
    task t_user;
        use_uc = 1'b1;
        kick(1'b0);
        finish_host;
        arm = 1'b1;
        for (int k = 0; k < 2600 && umode !== 1'b1; k++) @(posedge clk);
        arm = 1'b0;
        chk(uc_n >= 298 && uc_n <= 302, 1'b1);
        chk({err, umode}, 2'h1);
    endtask
    task end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        t_por;
        t_good;
        t_err;
        t_user;
        end_of_test;
    end
endmodule
`default_nettype wire
